// [core/tcg_cfg_pkg.sv]
// constants for the temperature, guard and processor configuration bank
package tcg_cfg_pkg;
    // ========================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] IDX_FIRST = 6'h13;
    localparam logic [5:0] IDX_LAST = 6'h1b;
    localparam int NUM_REGS = 9;
    localparam logic [5:0] IDX_GUARD_AMP_GAIN_TIMING = 6'h13;
    localparam logic [5:0] IDX_TEMP_CYCLE_GUARD_TRIM = 6'h14;
    localparam logic [5:0] IDX_TEMP_TRIGGER_DIVIDER_LOW = 6'h15;
    localparam logic [5:0] IDX_TEMP_TRIGGER_AVERAGE = 6'h16;
    localparam logic [5:0] IDX_TEMP_PORT_SELECT = 6'h17;
    localparam logic [5:0] IDX_TIME_CONV_INTERNAL_A = 6'h18;
    localparam logic [5:0] IDX_TIME_CONV_INTERNAL_B = 6'h19;
    localparam logic [5:0] IDX_TIME_CONV_INTERNAL_C = 6'h1a;
    localparam logic [5:0] IDX_PROCESSOR_PIN_ROUTING = 6'h1b;

    // ========================================================
    // writable bits per register, entry 0 is index 0x13
    localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
        8'hcf, 8'hfe, 8'hfc, 8'h3f, 8'hf7, 8'h7f, 8'hff, 8'h87, 8'hff
    };
    localparam logic [7:0] REG_RESET = 8'h00;

    // ========================================================
    // field positions
    localparam int GUARD_TIME_LSB = 0;
    localparam int GUARD_ATTEN_LSB = 4;
    localparam int GUARD_GAIN_LSB = 6;
    localparam int GUARD_TRIM_LSB = 0;
    localparam int TEMP_CYCLE_DOUBLE_BIT = 7;
    localparam int TRIG_DIV_HIGH_LSB = 0;
    localparam int TEMP_AVERAGE_COUNT_LSB = 2;
    localparam int TRIG_SRC_LSB = 4;
    localparam int TEMP_START_PIN_SELECT_LSB = 0;
    localparam int TEMP_WARMUP_BIT = 2;
    localparam int TEMP_INTERNAL_REF_ENABLE_BIT = 4;
    localparam int TEMP_INTERNAL_SENSOR_ENABLE_BIT = 5;
    localparam int EXT_REF_PORT_BIT = 6;
    localparam int EXT_SENSOR_PORT_BIT = 7;
    localparam int SWAP_PINS_ZERO_TWO_BIT = 0;
    localparam int SWAP_PINS_ONE_THREE_BIT = 1;
    localparam int PROC_SPEED_LSB = 2;
    localparam int PULSE_DEBOUNCE_ENABLE_LSB = 6;

    // ========================================================
    // encodings
    typedef enum logic [2:0] {
        TRIG_OFF = 3'h0,
        TRIG_TIMER = 3'h1,
        TRIG_PIN = 3'h3,
        TRIG_CAP_ASYNC = 3'h5,
        TRIG_CAP_SYNC = 3'h6
    } trig_src_e;
    localparam logic [1:0] DEBOUNCE_ON = 2'h3;
    localparam logic [3:0] WARMUP_SHORT = 4'h2;
    localparam logic [3:0] WARMUP_LONG = 4'h8;

    // ========================================================
    // timing
    localparam int CLOCK_PERIOD_PS = 8000;
    localparam int GUARD_STEP_NS = 500;
    localparam int GUARD_STEP_CYCLES = (GUARD_STEP_NS * 1000 + CLOCK_PERIOD_PS - 1)
        / CLOCK_PERIOD_PS;
    localparam int DEBOUNCE_NS = 10000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS * 1000 + CLOCK_PERIOD_PS - 1)
        / CLOCK_PERIOD_PS;
endpackage

// [core/tcg_cfg_bank.sv]
// configuration bank for the temperature converter, guard driver and pulse routing
`timescale 1ns/1ps
module tcg_cfg_bank
    import tcg_cfg_pkg::*;
#(
    parameter int DIV_WIDTH = 10,
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic LF_TICK,
    input wire logic CAP_CONV_END,
    input wire logic GUARD_PRECHARGE,
    input wire logic [3:0] GPIO_IN,
    input wire logic PROC_PULSE,
    output logic GUARD_TO_AMP,
    output logic [1:0] GUARD_GAIN,
    output logic [1:0] GUARD_ATTEN,
    output logic [2:0] GUARD_TRIM,
    output logic TEMP_CYCLE_TICK,
    output logic TEMP_START,
    output logic [4:0] TEMP_AVG_SAMPLES,
    output logic [3:0] TEMP_PORT_EN,
    output logic [3:0] TEMP_WARMUP,
    output logic [7:0] TIME_CONV_A,
    output logic [7:0] TIME_CONV_B,
    output logic [7:0] TIME_CONV_C,
    output logic [1:0] PROC_SPEED,
    output logic [3:0] PULSE_OUT
);

    // ========================================================
    // elaboration checks
    generate
        if (DIV_WIDTH != 10)
        begin : g_bad_div
            $error("divider width must be 10");
        end
        if (DEBOUNCE_LEN < 1 || DEBOUNCE_LEN > 65535)
        begin : g_bad_deb
            $error("debounce length out of range");
        end
    endgenerate

    localparam int GCW = 11;
    localparam logic [GCW-1:0] GUARD_STEP = GCW'(GUARD_STEP_CYCLES);
    localparam logic [15:0] DEB_LEN = 16'(DEBOUNCE_LEN);

    // the widest guard delay must fit the counter, or the switch would come early
    generate
        if (15 * GUARD_STEP_CYCLES >= (1 << GCW))
        begin : g_bad_guard
            $error("guard counter too narrow");
        end
    endgenerate

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic ack;
        logic [31:0] rdat;
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
        logic [3:0] pin_prev;
        logic [GCW-1:0] guard_cnt;
        logic guard_amp;
        logic lf_half;
        logic cyc_tick;
        logic [DIV_WIDTH-1:0] div_cnt;
        logic sync_pend;
        logic start;
        logic pulse_prev;
        logic [15:0] mono_cnt;
        logic [3:0] pulse_out;
    } state_s;

    state_s cur_ff;
    state_s nxt_st;

    // ========================================================
    // field views of the stored registers
    logic [7:0] r_gat;
    logic [7:0] r_cyc;
    logic [7:0] r_div;
    logic [7:0] r_avg;
    logic [7:0] r_port;
    logic [7:0] r_route;
    logic [DIV_WIDTH-1:0] div_n;
    logic [2:0] trig_src;

    assign r_gat = cur_ff.regs[IDX_GUARD_AMP_GAIN_TIMING - IDX_FIRST];
    assign r_cyc = cur_ff.regs[IDX_TEMP_CYCLE_GUARD_TRIM - IDX_FIRST];
    assign r_div = cur_ff.regs[IDX_TEMP_TRIGGER_DIVIDER_LOW - IDX_FIRST];
    assign r_avg = cur_ff.regs[IDX_TEMP_TRIGGER_AVERAGE - IDX_FIRST];
    assign r_port = cur_ff.regs[IDX_TEMP_PORT_SELECT - IDX_FIRST];
    assign r_route = cur_ff.regs[IDX_PROCESSOR_PIN_ROUTING - IDX_FIRST];
    assign div_n = {r_avg[TRIG_DIV_HIGH_LSB +: 2], r_div};
    assign trig_src = r_avg[TRIG_SRC_LSB +: 3];

    always_comb
    begin
        logic [5:0] idx;
        logic hit;
        logic [3:0] idx_off;
        logic trig_evt;
        logic [3:0] pin_edge;
        logic [GCW-1:0] guard_lim;
        logic pulse_f;
        logic pulse_rise;
        idx = ADR_I[7:2];
        hit = 1'b0;
        idx_off = 4'h0;
        trig_evt = 1'b0;
        pin_edge = 4'h0;
        guard_lim = '0;
        pulse_f = 1'b0;
        pulse_rise = 1'b0;
        nxt_st = cur_ff;

        // ====================================================
        // wishbone slave: ack one cycle after the request, write at the ack edge
        hit = (idx >= IDX_FIRST) && (idx <= IDX_LAST);
        idx_off = 4'(idx - IDX_FIRST);
        nxt_st.ack = CYC_I && STB_I && !cur_ff.ack;
        nxt_st.rdat = 32'h0;
        if (CYC_I && STB_I && !cur_ff.ack && hit)
        begin
            nxt_st.rdat = {24'h0, cur_ff.regs[idx_off] & REG_MASK[idx_off]};
        end
        if (CYC_I && STB_I && cur_ff.ack && WE_I && SEL_I[0] && hit)
        begin
            // mandatory values are stored as written; nothing forces them
            nxt_st.regs[idx_off] = DAT_I[7:0] & REG_MASK[idx_off];
        end

        // ====================================================
        // general pin synchroniser and edge detect
        // only the second and third flops feed logic; the first may still be settling
        nxt_st.pin_meta = GPIO_IN;
        nxt_st.pin_sync = cur_ff.pin_meta;
        nxt_st.pin_prev = cur_ff.pin_sync;
        pin_edge = cur_ff.pin_sync & ~cur_ff.pin_prev;

        // ====================================================
        // guard switch-over timer
        // 500 ns rounds up to whole cycles, so the switch is never early
        guard_lim = GCW'(r_gat[GUARD_TIME_LSB +: 4]) * GUARD_STEP;
        if (!GUARD_PRECHARGE)
        begin
            nxt_st.guard_cnt = '0;
            nxt_st.guard_amp = 1'b0;
        end
        else if (cur_ff.guard_cnt >= guard_lim)
        begin
            nxt_st.guard_amp = 1'b1;
        end
        else
        begin
            nxt_st.guard_cnt = cur_ff.guard_cnt + GCW'(1);
        end

        // ====================================================
        // temperature cycle clock from the low-freq oscillator
        nxt_st.cyc_tick = 1'b0;
        if (LF_TICK)
        begin
            if (r_cyc[TEMP_CYCLE_DOUBLE_BIT])
            begin
                nxt_st.lf_half = !cur_ff.lf_half;
                nxt_st.cyc_tick = cur_ff.lf_half;
            end
            else
            begin
                nxt_st.lf_half = 1'b0;
                nxt_st.cyc_tick = 1'b1;
            end
        end

        // ====================================================
        // trigger source and pre-divider
        nxt_st.start = 1'b0;
        case (trig_src)
            TRIG_TIMER:
            begin
                trig_evt = LF_TICK;
            end
            TRIG_PIN:
            begin
                trig_evt = pin_edge[r_port[TEMP_START_PIN_SELECT_LSB +: 2]];
            end
            TRIG_CAP_ASYNC:
            begin
                trig_evt = CAP_CONV_END;
            end
            TRIG_CAP_SYNC:
            begin
                // start waits for the next cycle tick so it lines up with the sequencer
                if (CAP_CONV_END)
                begin
                    nxt_st.sync_pend = 1'b1;
                end
                if (cur_ff.sync_pend && cur_ff.cyc_tick)
                begin
                    trig_evt = 1'b1;
                    nxt_st.sync_pend = CAP_CONV_END;
                end
            end
            default:
            begin
                trig_evt = 1'b0;
            end
        endcase
        if (trig_src != TRIG_CAP_SYNC)
        begin
            nxt_st.sync_pend = 1'b0;
        end
        if (trig_src == TRIG_OFF)
        begin
            nxt_st.div_cnt = '0;
        end
        else if (trig_evt)
        begin
            // a divider lowered below the running count fires on the next event
            if (div_n <= DIV_WIDTH'(1) || cur_ff.div_cnt >= div_n - DIV_WIDTH'(1))
            begin
                nxt_st.div_cnt = '0;
                nxt_st.start = 1'b1;
            end
            else
            begin
                nxt_st.div_cnt = cur_ff.div_cnt + DIV_WIDTH'(1);
            end
        end

        // ====================================================
        // pulse line: optional mono-flop, then pin routing
        nxt_st.pulse_prev = PROC_PULSE;
        pulse_rise = PROC_PULSE && !cur_ff.pulse_prev;
        if (r_route[PULSE_DEBOUNCE_ENABLE_LSB +: 2] == DEBOUNCE_ON)
        begin
            // edges while the mono-flop runs are swallowed; that is the anti-bounce
            if (cur_ff.mono_cnt != 16'h0)
            begin
                nxt_st.mono_cnt = cur_ff.mono_cnt - 16'h1;
            end
            else if (pulse_rise)
            begin
                nxt_st.mono_cnt = DEB_LEN;
            end
            pulse_f = (cur_ff.mono_cnt != 16'h0);
        end
        else
        begin
            nxt_st.mono_cnt = 16'h0;
            pulse_f = PROC_PULSE;
        end
        nxt_st.pulse_out = 4'h0;
        if (r_route[SWAP_PINS_ZERO_TWO_BIT])
        begin
            nxt_st.pulse_out[0] = pulse_f;
        end
        else
        begin
            nxt_st.pulse_out[2] = pulse_f;
        end
        if (r_route[SWAP_PINS_ONE_THREE_BIT])
        begin
            nxt_st.pulse_out[1] = pulse_f;
        end
        else
        begin
            nxt_st.pulse_out[3] = pulse_f;
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            cur_ff <= '0;
            cur_ff.regs <= {NUM_REGS{REG_RESET}};
        end
        else
        begin
            cur_ff <= nxt_st;
        end
    end

    // ========================================================
    // outputs
    always_comb
    begin
        case (r_avg[TEMP_AVERAGE_COUNT_LSB +: 2])
            2'h0: TEMP_AVG_SAMPLES = 5'h01;
            2'h1: TEMP_AVG_SAMPLES = 5'h04;
            2'h2: TEMP_AVG_SAMPLES = 5'h08;
            default: TEMP_AVG_SAMPLES = 5'h10;
        endcase
    end

    assign TEMP_WARMUP = r_port[TEMP_WARMUP_BIT] ? WARMUP_LONG : WARMUP_SHORT;
    assign TEMP_PORT_EN = {r_port[TEMP_INTERNAL_SENSOR_ENABLE_BIT],
                           r_port[TEMP_INTERNAL_REF_ENABLE_BIT],
                           r_port[EXT_SENSOR_PORT_BIT],
                           r_port[EXT_REF_PORT_BIT]};
    assign DAT_O = cur_ff.rdat;
    assign ACK_O = cur_ff.ack;
    assign GUARD_TO_AMP = cur_ff.guard_amp;
    assign GUARD_GAIN = r_gat[GUARD_GAIN_LSB +: 2];
    assign GUARD_ATTEN = r_gat[GUARD_ATTEN_LSB +: 2];
    assign GUARD_TRIM = r_cyc[GUARD_TRIM_LSB +: 3];
    assign TEMP_CYCLE_TICK = cur_ff.cyc_tick;
    assign TEMP_START = cur_ff.start;
    assign TIME_CONV_A = cur_ff.regs[IDX_TIME_CONV_INTERNAL_A - IDX_FIRST];
    assign TIME_CONV_B = cur_ff.regs[IDX_TIME_CONV_INTERNAL_B - IDX_FIRST];
    assign TIME_CONV_C = cur_ff.regs[IDX_TIME_CONV_INTERNAL_C - IDX_FIRST];
    assign PROC_SPEED = r_route[PROC_SPEED_LSB +: 2];
    assign PULSE_OUT = cur_ff.pulse_out;
endmodule

// [tb/tcg_cfg_bank_chk.sv]
// port-level assertion checker for the configuration bank
`timescale 1ns/1ps
module tcg_cfg_bank_chk
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic LF_TICK,
    input wire logic GUARD_PRECHARGE,
    input wire logic GUARD_TO_AMP,
    input wire logic TEMP_CYCLE_TICK,
    input wire logic TEMP_START,
    input wire logic [4:0] TEMP_AVG_SAMPLES,
    input wire logic [3:0] TEMP_WARMUP,
    input wire logic [3:0] PULSE_OUT
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // ==========================================
    // register access
    chk_ack_follows_req:
        assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("request not acked");
    chk_ack_single_pulse:
        assert property (ACK_O |=> !ACK_O) else $error("ack held too long");
    chk_read_upper_zero:
        assert property (DAT_O[31:8] == 24'h0) else $error("upper read bits set");
    chk_idle_data_zero:
        assert property (!ACK_O |-> DAT_O == 32'h0) else $error("data without ack");
    // ==========================================
    // guard, temperature and pulse outputs, plus ack cause
    chk_guard_direct_idle:
        assert property (!GUARD_PRECHARGE |=> !GUARD_TO_AMP) else $error("amp outside precharge");
    chk_guard_amp_cause:
        assert property ($rose(GUARD_TO_AMP) |-> $past(GUARD_PRECHARGE)) else $error("early amp");
    chk_cycle_tick_cause:
        assert property (TEMP_CYCLE_TICK |-> $past(LF_TICK)) else $error("tick without osc");
    chk_avg_count_legal:
        assert property (TEMP_AVG_SAMPLES inside {5'h01, 5'h04, 5'h08, 5'h10})
            else $error("bad average count");
    chk_warmup_legal:
        assert property (TEMP_WARMUP inside {4'h2, 4'h8}) else $error("bad warm-up count");
    chk_pulse_pin_pairs:
        assert property (!(PULSE_OUT[0] && PULSE_OUT[2]) && !(PULSE_OUT[1] && PULSE_OUT[3]))
            else $error("pulse on both pins of a pair");
    chk_ack_has_req:
        assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("ack without request");
    chk_amp_needs_pre:
        assert property (GUARD_TO_AMP |-> $past(GUARD_PRECHARGE)) else $error("amp without precharge");
    cover property (ACK_O);
    cover property ($rose(PULSE_OUT[1]));
    cover property ($rose(GUARD_TO_AMP));
    cover property (TEMP_START);
endmodule

bind tcg_cfg_bank tcg_cfg_bank_chk i_chk (.CLOCK(CLOCK), .RST(RST), .CYC_I(CYC_I),
    .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .LF_TICK(LF_TICK),
    .GUARD_PRECHARGE(GUARD_PRECHARGE), .GUARD_TO_AMP(GUARD_TO_AMP),
    .TEMP_CYCLE_TICK(TEMP_CYCLE_TICK), .TEMP_START(TEMP_START),
    .TEMP_AVG_SAMPLES(TEMP_AVG_SAMPLES), .TEMP_WARMUP(TEMP_WARMUP), .PULSE_OUT(PULSE_OUT));

// [tb/tb_tcg_cfg_bank.sv]
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module tb_tcg_cfg_bank import tcg_cfg_pkg::*;;
    localparam int DBL = 4;
    logic CLOCK = 0, RST = 1, CYC_I = 0, STB_I = 0, WE_I = 0, LF_TICK = 0;
    logic CAP_CONV_END = 0, GUARD_PRECHARGE = 0, PROC_PULSE = 0, ACK_O, GUARD_TO_AMP;
    logic TEMP_CYCLE_TICK, TEMP_START;
    logic [7:0] ADR_I = 0, TIME_CONV_A, TIME_CONV_B, TIME_CONV_C;
    logic [3:0] SEL_I = 0, GPIO_IN = 0, TEMP_PORT_EN, TEMP_WARMUP, PULSE_OUT;
    logic [31:0] DAT_I = 0, DAT_O, rdata;
    logic [1:0] GUARD_GAIN, GUARD_ATTEN, PROC_SPEED;
    logic [2:0] GUARD_TRIM;
    logic [4:0] TEMP_AVG_SAMPLES;
    int num_errors = 0, comparisons = 0, n_start = 0, n_tick = 0;

    tcg_cfg_bank #(.DIV_WIDTH(10), .DEBOUNCE_LEN(DBL)) i_dut (.CLOCK(CLOCK), .RST(RST),
        .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
        .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .LF_TICK(LF_TICK),
        .CAP_CONV_END(CAP_CONV_END), .GUARD_PRECHARGE(GUARD_PRECHARGE), .GPIO_IN(GPIO_IN),
        .PROC_PULSE(PROC_PULSE), .GUARD_TO_AMP(GUARD_TO_AMP), .GUARD_GAIN(GUARD_GAIN),
        .GUARD_ATTEN(GUARD_ATTEN), .GUARD_TRIM(GUARD_TRIM), .TEMP_CYCLE_TICK(TEMP_CYCLE_TICK),
        .TEMP_START(TEMP_START), .TEMP_AVG_SAMPLES(TEMP_AVG_SAMPLES),
        .TEMP_PORT_EN(TEMP_PORT_EN), .TEMP_WARMUP(TEMP_WARMUP), .TIME_CONV_A(TIME_CONV_A),
        .TIME_CONV_B(TIME_CONV_B), .TIME_CONV_C(TIME_CONV_C), .PROC_SPEED(PROC_SPEED),
        .PULSE_OUT(PULSE_OUT));

    always #4 CLOCK = ~CLOCK;
    always @(posedge CLOCK) if (TEMP_START === 1'b1) n_start++;
    always @(posedge CLOCK) if (TEMP_CYCLE_TICK === 1'b1) n_tick++;

    // ==========================================
    // checking and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one classic cycle, entered and left just after a rising edge
    task automatic wb(input logic [5:0] idx, input logic we, input logic [3:0] sel,
        input logic [7:0] d);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= {idx, 2'b00};
        SEL_I <= sel;
        DAT_I <= {24'h0, d};
        @(posedge CLOCK);
        while (ACK_O !== 1'b1) @(posedge CLOCK);
        rdata = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        wb(idx, 1'b1, 4'hf, d);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        wb(idx, 1'b0, 4'hf, 8'h00);
        chk(rdata, {24'h0, exp}, "read data");
    endtask

    // m: [0] osc tick, [1] cap end, [5:2] general pins; osc tick trails the others
    task automatic ev(input logic [5:0] m, input int n);
        repeat (n)
        begin
            CAP_CONV_END <= m[1];
            GPIO_IN <= m[5:2];
            @(posedge CLOCK);
            CAP_CONV_END <= 1'b0;
            repeat (2) @(posedge CLOCK);
            LF_TICK <= m[0];
            @(posedge CLOCK);
            LF_TICK <= 1'b0;
            repeat (3) @(posedge CLOCK);
            GPIO_IN <= 4'h0;
            repeat (5) @(posedge CLOCK);
        end
    endtask

    // source off first so the divider count starts clean
    task automatic trig(input logic [2:0] src, input logic [9:0] div, input logic [5:0] m,
        input int n, input int exp);
        wr(IDX_TEMP_TRIGGER_AVERAGE, 8'h00);
        wr(IDX_TEMP_TRIGGER_DIVIDER_LOW, div[7:0]);
        wr(IDX_TEMP_TRIGGER_AVERAGE, {1'b0, src, 2'b00, div[9:8]});
        n_start = 0;
        ev(m, n);
        chk(32'(n_start), 32'(exp), "start count");
    endtask

    task automatic guard(input logic [3:0] f);
        int n = 0;
        wr(IDX_GUARD_AMP_GAIN_TIMING, {4'h9, f});
        chk({30'h0, GUARD_GAIN}, 32'h2, "gain");
        chk({30'h0, GUARD_ATTEN}, 32'h1, "attenuation");
        GUARD_PRECHARGE <= 1'b1;
        while (GUARD_TO_AMP !== 1'b1 && n < 1000)
        begin
            @(posedge CLOCK);
            n++;
        end
        chk(32'(n > GUARD_STEP_CYCLES * f && n <= GUARD_STEP_CYCLES * f + 3), 32'h1,
            "guard delay");
        GUARD_PRECHARGE <= 1'b0;
        repeat (3) @(posedge CLOCK);
        chk({31'h0, GUARD_TO_AMP}, 32'h0, "guard after precharge");
    endtask

    // a bounce: second edge three cycles after the first
    task automatic pulse(input logic [7:0] cfg, input logic [3:0] pins, input int len);
        logic [3:0] acc = 4'h0;
        int hi = 0;
        wr(IDX_PROCESSOR_PIN_ROUTING, cfg);
        chk({30'h0, PROC_SPEED}, {30'h0, cfg[3:2]}, "speed");
        for (int i = 0; i < 16; i++)
        begin
            PROC_PULSE <= (i == 0 || i == 3);
            @(posedge CLOCK);
            acc |= PULSE_OUT;
            hi += int'(PULSE_OUT != 4'h0);
        end
        chk({28'h0, acc}, {28'h0, pins}, "pulse pins");
        chk(32'(hi), 32'(len), "pulse length");
    endtask

    // ==========================================
    // test sequence
    initial
    begin
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        for (int i = 0; i < NUM_REGS; i++) rd(IDX_FIRST + 6'(i), 8'h00);
        for (int i = 0; i < NUM_REGS; i++) wr(IDX_FIRST + 6'(i), 8'hff);
        for (int i = 0; i < NUM_REGS; i++) rd(IDX_FIRST + 6'(i), REG_MASK[i]);
        wr(6'h12, 8'hff);
        rd(6'h12, 8'h00);
        wb(IDX_TEMP_TRIGGER_DIVIDER_LOW, 1'b1, 4'he, 8'h5a);
        rd(IDX_TEMP_TRIGGER_DIVIDER_LOW, 8'hff);
        wr(IDX_TIME_CONV_INTERNAL_A, 8'h33);
        wr(IDX_TIME_CONV_INTERNAL_B, 8'h04);
        wr(IDX_TIME_CONV_INTERNAL_C, 8'h52);
        chk({TIME_CONV_C, TIME_CONV_B, TIME_CONV_A}, 32'h520433, "time conv");
        $display("test registers finished");
        for (int i = 0; i < 4; i++)
        begin
            wr(IDX_TEMP_TRIGGER_AVERAGE, 8'(i << 2));
            chk({27'h0, TEMP_AVG_SAMPLES}, (i == 0) ? 32'h1 : 32'(2 << i), "average");
        end
        wr(IDX_TEMP_PORT_SELECT, 8'hf4);
        chk({24'h0, TEMP_PORT_EN, TEMP_WARMUP}, 32'hf8, "ports warm-up");
        for (int i = 4; i < 8; i++)
        begin
            wr(IDX_TEMP_PORT_SELECT, 8'(1 << i));
            // bits 4,5 land on port enables 2,3 and bits 6,7 on enables 0,1
            chk({24'h0, TEMP_PORT_EN, TEMP_WARMUP},
                (i < 6) ? (32'h40 << (i - 4)) | 32'h2 : (32'h10 << (i - 6)) | 32'h2,
                "port select");
        end
        $display("test decode finished");
        guard(4'h0);
        guard(4'h1);
        guard(4'hf);
        wr(IDX_TEMP_CYCLE_GUARD_TRIM, 8'h07);
        chk({29'h0, GUARD_TRIM}, 32'h7, "trim");
        n_tick = 0;
        ev(6'h01, 4);
        chk(32'(n_tick), 32'h4, "cycle ticks");
        wr(IDX_TEMP_CYCLE_GUARD_TRIM, 8'h87);
        n_tick = 0;
        ev(6'h01, 4);
        chk(32'(n_tick), 32'h2, "doubled ticks");
        wr(IDX_TEMP_CYCLE_GUARD_TRIM, 8'h07);
        $display("test guard and cycle finished");
        wr(IDX_TEMP_PORT_SELECT, 8'h02);
        trig(3'h1, 10'd3, 6'h01, 6, 2);
        trig(3'h1, 10'd0, 6'h01, 3, 3);
        trig(3'h5, 10'd2, 6'h02, 6, 3);
        trig(3'h5, 10'd1, 6'h01, 3, 0);
        trig(3'h6, 10'd1, 6'h03, 3, 3);
        trig(3'h3, 10'd1, 6'h10, 3, 3);
        trig(3'h3, 10'd1, 6'h04, 3, 0);
        trig(3'h0, 10'd1, 6'h3f, 3, 0);
        trig(3'h1, 10'h3ff, 6'h01, 1023, 1);
        $display("test trigger finished");
        pulse(8'h00, 4'hc, 2);
        pulse(8'h07, 4'h3, 2);
        pulse(8'h09, 4'h9, 2);
        pulse(8'hce, 4'h6, DBL);
        $display("test pulse finished");
        give_verdict;
    end

    initial
    begin
        repeat (60000) @(posedge CLOCK);
        num_errors++;
        $display("BAD at %0t: watchdog expired", $time);
        give_verdict;
    end
endmodule
